// File: core/ssl_shifter.sv
// Serial status indicator shifter with its bit FIFO and AXI4-Lite registers.
// Assumes port status comes from logic on aclk; AXI master on aclk.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "ssl_defs.svh"
`default_nettype none

module ssl_fifo #(
  parameter int W = 1,
  parameter int D = 16
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  assign in_ready  = (count != (AW+1)'(D));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // ssl_fifo

////////////////////////////////////////////////////////////////////////////////

module ssl_shifter #(
  parameter int PORTS          = 8,
  parameter int PINS           = 4,
  parameter int FIFO_DEPTH     = 16,
  parameter int BLINK_HALF_CYC = `SSL_BLINK_HALF_CYC
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [7:0]                    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [7:0]                    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire ssl_pkg::ssl_status_t [PORTS-1:0] port_status,
  output logic [PORTS*PINS-1:0]              indicator_pin
);
  localparam logic [3:0] SCLK_HALF = 4'(`SSL_SCLK_HALF_CYC);

  ssl_pkg::ssl_port_cfg_t [PORTS-1:0] port_cfg;
  logic [PORTS-1:0][PINS*4-1:0]       pin_mode;
  logic [PORTS-1:0][4:0]              shaped;
  logic [PORTS-1:0][4:0]              stretched;
  logic [PORTS-1:0]                   period_end;
  logic [31:0] blink_cnt;
  logic        blink_tick;
  logic [3:0]  phase;
  logic        serial_on;
  logic [2:0]  b_port;
  logic [3:0]  b_pos;
  logic [7:0]  frame_count;
  logic        f_in_ready;
  logic        f_out_valid;
  logic        f_out_data;
  logic        f_pop;
  logic [3:0]  half_cnt;
  logic        sclk;
  logic        sdata;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // Level of one indicator in its own mode, active low
  function automatic logic ind_level(input logic [3:0] mode, input ssl_pkg::ssl_status_t s,
                                     input logic comb, input logic [4:0] sh);
    logic lk;
    logic on;
    lk = 1'b0;
    on = 1'b0;
    unique case (mode)
      4'h0: lk = s.link_any;
      4'h1: lk = s.link1000;
      4'h2: lk = s.link100;
      4'h3: lk = s.link10;
      4'h4: lk = s.link100 | s.link1000;
      4'h5: lk = s.link10 | s.link1000;
      4'h6: lk = s.link10 | s.link100;
      4'h7: lk = s.link_fiber;
      default: lk = 1'b0;
    endcase
    unique case (mode)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7:
        on = lk & ~(comb & sh[0]);                       // see R9
      4'h8: on = s.full_duplex | (s.link_any & comb & sh[1]);
      4'h9: on = sh[1];
      4'hA: on = sh[0];
      4'hB: on = sh[2];
      4'hC: on = s.aneg_fault;
      4'hF: on = 1'b1;
      default: on = 1'b0;                                // see R8
    endcase
    return ~on;
  endfunction

  // One bit of a port group, by position
  function automatic logic serial_bit(input logic [3:0] pos, input ssl_pkg::ssl_status_t s,
                                      input logic comb, input logic [4:0] sh);
    logic b;
    b = 1'b1;
    unique case (pos)                                     // see R7
      4'd0:  b = ind_level(4'h0, s, comb, sh);
      4'd1:  b = ind_level(4'h1, s, comb, sh);
      4'd2:  b = ind_level(4'h2, s, comb, sh);
      4'd3:  b = ind_level(4'h3, s, comb, sh);
      4'd5:  b = ind_level(4'h8, s, comb, sh);
      4'd6:  b = ind_level(4'h9, s, comb, sh);
      4'd7:  b = ind_level(4'hA, s, comb, sh);
      4'd9:  b = ~sh[3];
      4'd10: b = ~sh[4];
      4'd11: b = ind_level(4'hC, s, comb, sh);
      default: b = 1'b1;
    endcase
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Blink base: phase[0] is 20 Hz, phase[3] is 2.5 Hz

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_cnt  <= '0;
      blink_tick <= 1'b0;
      phase      <= '0;
    end else begin
      blink_tick <= (blink_cnt == 32'(BLINK_HALF_CYC - 1));
      blink_cnt  <= (blink_cnt == 32'(BLINK_HALF_CYC - 1)) ? '0 : blink_cnt + 1'b1;
      if (blink_tick) begin
        phase <= phase + 1'b1;
      end
    end
  end

  // Stretch lasts until the selected period ends, matching 50 to 400 ms
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    logic [4:0] ev;
    logic [1:0] k;
    assign ev = {port_status[p].rx_activity, port_status[p].tx_activity,
                 port_status[p].fiber_activity, port_status[p].collision, port_status[p].activity};
    assign k  = 2'd3 - port_cfg[p].rate;
    assign period_end[p] = blink_tick & ((phase & (4'hF >> (3 - k))) == (4'hF >> (3 - k)));
    assign shaped[p] = port_cfg[p].stretch ? stretched[p] : (ev & {5{phase[k]}});  // see R10, R5
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        stretched[p] <= '0;
      end else begin
        stretched[p] <= ev | (stretched[p] & {5{~period_end[p]}});   // set wins over the end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame builder feeding the FIFO; it stalls while the FIFO is full

  assign serial_on = (pin_mode[0][3:0] == `SSL_MODE_SERIAL);   // see R1, R8

  always_ff @(posedge aclk) begin
    if (!aresetn || !serial_on) begin
      b_port <= '0;
      b_pos  <= '0;
    end else if (f_in_ready) begin
      if (b_pos == 4'(`SSL_GROUP_BITS - 1)) begin
        b_pos  <= '0;
        b_port <= b_port + 1'b1;                                   // see R6
      end else begin
        b_pos <= b_pos + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_count <= '0;
    end else if (serial_on && f_in_ready && b_port == 3'd7 && b_pos == 4'(`SSL_GROUP_BITS - 1)) begin
      frame_count <= frame_count + 1'b1;                            // see R4, R11
    end
  end

  ssl_fifo #(.W(1), .D(FIFO_DEPTH)) ssl_fifo_inst (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .flush     (~serial_on),
    .in_valid  (serial_on),
    .in_ready  (f_in_ready),
    .in_data   (serial_bit(b_pos, port_status[b_port], port_cfg[b_port].combine, shaped[b_port])),
    .out_valid (f_out_valid),
    .out_ready (f_pop),
    .out_data  (f_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Serial clock divider; a falling edge waits for a bit to be ready

  assign f_pop = serial_on & sclk & (half_cnt == SCLK_HALF - 1'b1) & f_out_valid;

  always_ff @(posedge aclk) begin
    if (!aresetn || !serial_on) begin
      half_cnt <= '0;
      sclk     <= 1'b1;
      sdata    <= 1'b1;
    end else if (half_cnt == SCLK_HALF - 1'b1) begin
      if (!sclk) begin
        sclk     <= 1'b1;                                            // see R4
        half_cnt <= '0;
      end else if (f_out_valid) begin
        sclk     <= 1'b0;
        sdata    <= f_out_data;                                      // see R11
        half_cnt <= '0;
      end
    end else begin
      half_cnt <= half_cnt + 1'b1;
    end
  end

  for (genvar i = 0; i < PORTS * PINS; i++) begin : g_pin
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        indicator_pin[i] <= 1'b1;
      end else if (serial_on && i == 0) begin
        indicator_pin[i] <= sdata;                                   // see R2
      end else if (serial_on && i == 1) begin
        indicator_pin[i] <= sclk;                                    // see R2
      end else begin
        indicator_pin[i] <= ind_level(pin_mode[i / PINS][(i % PINS) * 4 +: 4], port_status[i / PINS],
                                      port_cfg[i / PINS].combine, shaped[i / PINS]);   // see R3
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: one write and one read at a time

  // Readies are registered; each one is the idle test of the next state, so timing matches a decode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_awready <= ~aw_held & ~(s_axi_awvalid & s_axi_awready) & ~(s_axi_bvalid & ~s_axi_bready);
      s_axi_wready  <= ~w_held & ~(s_axi_wvalid & s_axi_wready) & ~(s_axi_bvalid & ~s_axi_bready);
      s_axi_arready <= ~(s_axi_arvalid & s_axi_arready) & ~(s_axi_rvalid & ~s_axi_rready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SSL_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr >= `SSL_CFG_BASE && aw_addr < `SSL_MODE_BASE + 8'(4 * PORTS) &&
                         aw_addr[1:0] == 2'b00) ? `SSL_RESP_OKAY : `SSL_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  for (genvar p = 0; p < PORTS; p++) begin : g_reg
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        port_cfg[p] <= `SSL_CFG_RESET;
        pin_mode[p] <= `SSL_MODE_RESET;
      end else if (aw_held && w_held) begin
        if (aw_addr == `SSL_CFG_BASE + 8'(4 * p) && w_strb[0]) begin
          port_cfg[p] <= w_data[3:0];
        end
        if (aw_addr == `SSL_MODE_BASE + 8'(4 * p)) begin
          if (w_strb[0]) pin_mode[p][7:0] <= w_data[7:0];
          if (w_strb[1]) pin_mode[p][15:8] <= w_data[15:8];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `SSL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `SSL_RESP_SLVERR;
      if (s_axi_araddr == `SSL_STATUS_OFF) begin
        s_axi_rdata <= {16'h0000, frame_count, 7'h00, serial_on};
        s_axi_rresp <= `SSL_RESP_OKAY;
      end
      for (int p = 0; p < PORTS; p++) begin
        if (s_axi_araddr == `SSL_CFG_BASE + 8'(4 * p)) begin
          s_axi_rdata <= {28'h0000000, port_cfg[p]};
          s_axi_rresp <= `SSL_RESP_OKAY;
        end
        if (s_axi_araddr == `SSL_MODE_BASE + 8'(4 * p)) begin
          s_axi_rdata <= {16'h0000, pin_mode[p]};
          s_axi_rresp <= `SSL_RESP_OKAY;
        end
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // ssl_shifter

`default_nettype wire

// File: core/ssl_defs.svh
// Constants of the serial status indicator shifter.
// Assumes a 10 MHz aclk and a bench serial clock period of 800 ns.
//
// Functional notes
// R1 - Serial operation starts only when port zero's first indicator selects serial mode.
// R2 - When serial, pin zero carries serial data and pin one the serial clock.
// R3 - All other indicator pins keep their normal per-pin mode behaviour.
// R4 - Frame holds 96 bits; receiver samples data on rising serial clock.
// R5 - Each port's combine and blink/stretch settings shape all that port's serial bits; the fault bit and the reserved bits are not shaped.
// R6 - Frame sends port 0 group first and port 7 group last.
// R7 - Group order: any,1000,100,10 link, reserved, duplex, collision, activity, reserved, tx, rx, fault.
// R8 - Mode code 13 means serial on port zero only, reserved elsewhere.
// R9 - Link bits active low; blink or pulse with activity when combine enabled.
// R10 - Blink rate selectable 2.5, 5, 10 or 20 Hz at 50 percent duty.
// R11 - Data changes on falling serial clock; frame repeats while serial mode stays.
`ifndef SSL_DEFS_SVH
`define SSL_DEFS_SVH
`define SSL_STATUS_OFF     8'h00
`define SSL_CFG_BASE       8'h10
`define SSL_MODE_BASE      8'h30
`define SSL_CFG_COMBINE    0
`define SSL_CFG_STRETCH    1
`define SSL_CFG_RATE_LSB   2
`define SSL_CFG_RESET      4'h0
`define SSL_MODE_RESET     16'h0000
`define SSL_MODE_SERIAL    4'hD
`define SSL_FRAME_BITS     96
`define SSL_GROUP_BITS     12
`define SSL_CLK_HZ         10000000
`define SSL_CLK_PERIOD_NS  100
`define SSL_SCLK_PERIOD_NS 800
`define SSL_SCLK_HALF_CYC  ((`SSL_SCLK_PERIOD_NS / `SSL_CLK_PERIOD_NS) / 2)
`define SSL_BLINK_MAX_HZ   20
`define SSL_BLINK_HALF_CYC (`SSL_CLK_HZ / (2 * `SSL_BLINK_MAX_HZ))
`define SSL_RESP_OKAY      2'h0
`define SSL_RESP_SLVERR    2'h2
`endif

// File: core/ssl_pkg.sv
// Types of the serial status indicator shifter.
// Assumes the constants header is included by the design file.
package ssl_pkg;
  typedef struct packed {
    logic link_any;
    logic link1000;
    logic link100;
    logic link10;
    logic link_fiber;
    logic full_duplex;
    logic collision;
    logic activity;
    logic fiber_activity;
    logic tx_activity;
    logic rx_activity;
    logic aneg_fault;
  } ssl_status_t;

  typedef struct packed {
    logic [1:0] rate;
    logic       stretch;
    logic       combine;
  } ssl_port_cfg_t;
endpackage

// File: verification/ssl_chain_model.sv
// Model of the external shift-register chain fed by the serial indicator pins.
// Assumes data and clock come straight from the two repurposed indicator pins.
`timescale 1ns/1ns
`default_nettype none

module ssl_chain_model (
  input  wire logic   sdata,
  input  wire logic   sclk,
  output var  logic [95:0] frame,
  output var  int     nbits
);
  initial begin
    frame = '0;
    nbits = 0;
  end

  // Newest bit enters at the bottom, so bit 1 of a frame ends at the top
  always @(posedge sclk) begin
    frame <= {frame[94:0], sdata};
    nbits <= nbits + 1;
  end
endmodule // ssl_chain_model

`default_nettype wire

// File: verification/ssl_shifter_assertions.sv
// Checker for the serial status shifter, bound to its top module.
// Assumes one clock domain and the synchronous active low reset.
`timescale 1ns/1ns
`default_nettype none

module ssl_shifter_assertions #(
  parameter int PORTS = 8,
  parameter int PINS  = 4
) (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic [7:0]           s_axi_awaddr,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic [31:0]          s_axi_wdata,
  input wire logic [3:0]           s_axi_wstrb,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic [7:0]           s_axi_araddr,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic [1:0]           s_axi_rresp,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire ssl_pkg::ssl_status_t [PORTS-1:0] port_status,
  input wire logic [PORTS*PINS-1:0] indicator_pin
);
  logic       c;
  logic       d;
  logic       c_q;
  logic [2:0] hi_cnt;
  logic [6:0] pos;

  assign c = indicator_pin[1];
  assign d = indicator_pin[0];

  ////////////////////////////////////////////////////////////////////////////////
  // A high time above 5 cycles means idle, which realigns the bit position
  always_ff @(posedge aclk) begin
    c_q <= c;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !c) hi_cnt <= 3'h0;
    else if (hi_cnt != 3'h7) hi_cnt <= hi_cnt + 3'h1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || hi_cnt > 3'h5) pos <= 7'h00;
    else if (c && !c_q) pos <= (pos == 7'h5F) ? 7'h00 : pos + 7'h01;
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_high4;
    c [*4];
  endsequence
  sequence s_low4_rise;
    !c [*4] ##1 c;
  endsequence

  property p_reset_idle;
    $rose(aresetn) |-> indicator_pin == '1;
  endproperty
  property p_data_on_fall;
    $changed(d) |-> $fell(c) || (d && c);
  endproperty
  property p_high_half;
    $rose(c) |-> s_high4;
  endproperty
  property p_low_half;
    $fell(c) |-> s_low4_rise or ##[1:4] (c && d);
  endproperty
  property p_data_hold;
    $rose(c) |=> ($stable(d) || (c && d)) [*3];
  endproperty
  property p_reserved;
    (c && !c_q && (pos % 12 == 4 || pos % 12 == 8)) |-> d;
  endproperty
  property p_write_ans;
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |-> ##2 s_axi_bvalid;
  endproperty
  property p_read_ans;
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid;
  endproperty

  a_reset_idle: assert property (p_reset_idle) else $error("pins not idle after reset");
  a_data_on_fall: assert property (p_data_on_fall) else $error("data moved off a falling clock");
  a_high_half: assert property (p_high_half) else $error("serial clock high half short");
  a_low_half: assert property (p_low_half) else $error("serial clock low half wrong");
  a_data_hold: assert property (p_data_hold) else $error("data moved in high half");
  a_reserved: assert property (p_reserved) else $error("reserved slot not high");
  a_write_ans: assert property (p_write_ans) else $error("write response late");
  a_read_ans: assert property (p_read_ans) else $error("read response late");
endmodule // ssl_shifter_assertions

bind ssl_shifter ssl_shifter_assertions #(.PORTS(PORTS), .PINS(PINS)) ssl_shifter_assertions_inst (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .port_status, .indicator_pin
);

`default_nettype wire

// File: verification/ssl_shifter_tb_top.sv
// Bench for the serial status shifter: AXI4-Lite master, status driver, frame compare.
// Assumes the chain model and the bound checker are compiled with the design.
`timescale 1ns/1ns
`include "ssl_defs.svh"
`default_nettype none

module ssl_shifter_tb_top;
  logic                       aclk, aresetn;
  logic [7:0]                 s_axi_awaddr, s_axi_araddr;
  logic [31:0]                s_axi_wdata, s_axi_rdata;
  logic [3:0]                 s_axi_wstrb;
  logic [1:0]                 s_axi_bresp, s_axi_rresp;
  logic                       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                       s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                       s_axi_rvalid, s_axi_rready;
  ssl_pkg::ssl_status_t [7:0] port_status;
  logic [31:0]                indicator_pin;
  logic [95:0]                frame;
  int                         nbits, err_count, tests_run;

  // Short blink half period keeps blink phases visible in a short run
  ssl_shifter #(.BLINK_HALF_CYC(4)) ssl_shifter_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .port_status, .indicator_pin
  );
  ssl_chain_model ssl_chain_model_inst (.sdata(indicator_pin[0]), .sclk(indicator_pin[1]), .frame, .nbits);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // No wait limit here: only the watchdog ends a hung transfer
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    dat = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Link bits and fault active low; reserved and idle event slots read 1
  function automatic logic [95:0] exp_frame();
    logic [95:0]          f;
    ssl_pkg::ssl_status_t s;
    for (int p = 0; p < 8; p++) begin
      s = port_status[p];
      f[95-12*p -: 12] = {~s.link_any, ~s.link1000, ~s.link100, ~s.link10, 1'b1, ~s.full_duplex, 5'h1F, ~s.aneg_fault};
    end
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] dat;
    logic [1:0]  r;
    @(negedge aclk);
    check(indicator_pin, 32'hFFFFFFFF);
    axi_rd(8'h04, dat, r);
    check(r, `SSL_RESP_SLVERR);
    axi_wr(`SSL_STATUS_OFF, 32'h00000001, r);
    check(r, `SSL_RESP_SLVERR);
    axi_wr(`SSL_MODE_BASE + 8'h04, {28'h0, `SSL_MODE_SERIAL}, r);
    repeat (20) @(posedge aclk);
    check({indicator_pin[4], indicator_pin[1:0]}, 3'h7);
    axi_rd(`SSL_STATUS_OFF, dat, r);
    check(dat[0], 1'b0);
    axi_wr(`SSL_MODE_BASE + 8'h04, 32'h00000000, r);
    $display("t_regs done");
  endtask

  // Port 0 pins forced off first, so entering serial mode makes no stray clock edge
  task automatic t_frame(input int mult);
    logic [31:0] dat;
    logic [1:0]  r;
    int          n0, n;
    axi_wr(`SSL_MODE_BASE, 32'h0000EEEE, r);
    @(posedge aclk);
    for (int p = 0; p < 8; p++) port_status[p] <= ssl_pkg::ssl_status_t'(12'((12'h935 * (p + mult)) & 12'hF41));
    axi_wr(`SSL_MODE_BASE, 32'h00000F0D, r);
    n0 = nbits;
    n = 0;
    while (nbits != n0 + 192 && n < 4000) begin
      @(negedge aclk);
      n++;
    end
    check(nbits - n0, 192);
    check(frame, exp_frame());
    check(indicator_pin[2], 1'b0);
    check(indicator_pin[4] ^ port_status[1].link_any, 1'b1);
    axi_rd(`SSL_STATUS_OFF, dat, r);
    check(dat[0], 1'b1);
    axi_wr(`SSL_MODE_BASE, 32'h0000EEEE, r);
    repeat (4) @(posedge aclk);
    check(indicator_pin[1:0], 2'h3);
    $display("t_frame done");
  endtask

  // Port 3 combines with stretched activity: its link bits go off, its activity bit on
  task automatic t_combine();
    logic [95:0] e;
    logic [1:0]  r;
    int          n0, n;
    axi_wr(`SSL_CFG_BASE + 8'h0C, 32'h00000003, r);
    port_status[3].activity <= 1'b1;
    axi_wr(`SSL_MODE_BASE, 32'h00000F0D, r);
    n0 = nbits;
    n = 0;
    while (nbits != n0 + 192 && n < 4000) begin
      @(negedge aclk);
      n++;
    end
    e = exp_frame();
    e[59:56] = 4'hF;
    e[52] = 1'b0;
    check(nbits - n0, 192);
    check(frame, e);
    axi_wr(`SSL_MODE_BASE, 32'h0000EEEE, r);
    $display("t_combine done");
  endtask

  // Activity pin of port 2: fastest rate toggles each 4 cycles, slowest each 32
  task automatic t_blink();
    logic [1:0] r;
    logic       prev;
    int         n;
    axi_wr(`SSL_MODE_BASE + 8'h08, 32'h0000000A, r);
    port_status[2].activity <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      axi_wr(`SSL_CFG_BASE + 8'h08, i ? 32'h00000000 : 32'h0000000C, r);
      repeat (4) @(negedge aclk);
      n = 0;
      prev = indicator_pin[8];
      repeat (64) begin
        @(negedge aclk);
        n += (indicator_pin[8] != prev);
        prev = indicator_pin[8];
      end
      check(n, i ? 2 : 16);
    end
    $display("t_blink done");
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  initial begin
    {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    port_status = '0;
    err_count = 0;
    tests_run = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_frame(1);
    t_frame(5);
    t_combine();
    t_blink();
    report_and_stop();
  end

  // Three frame scenarios of some 1700 cycles each plus short ones; 20000 leaves ample margin
  initial begin
    #2000000;
    err_count++;
    report_and_stop();
  end
endmodule // ssl_shifter_tb_top

`default_nettype wire
